// file: tb/pmc_core_model.sv
// Purpose: core-side stack memory for mode byte save and load
// Assumes: low four address bits select the byte
// Notes:   unwritten bytes read 0xa5 so a missed store shows up
`timescale 1ns/1ps
module pmc_core_model (
  input  wire logic        clk_sys,   // processor clock
  input  wire logic        mem_we,    // mode byte store
  input  wire logic [15:0] mem_addr,  // store address
  input  wire logic [7:0]  mem_wdata, // stored byte
  input  wire logic [15:0] rd_addr,   // stack pointer
  output logic      [7:0]  mem_rdata  // byte at pointer
);
  logic [7:0] mem [16];
  // ==========================================================
  // store on pulse, answer the pointer at once
  initial foreach (mem[i]) mem[i] = 8'ha5;
  always @(posedge clk_sys) if (mem_we) mem[mem_addr[3:0]] <= mem_wdata;
  assign mem_rdata = mem[rd_addr[3:0]];
endmodule

// file: tb/pmc_props.sv
// Purpose: port checks for privilege mode control
// Assumes: bound onto pmc_top, one clock domain
// Notes:   ops are only looked at while the block is idle
`timescale 1ns/1ps
module pmc_props (
  input wire logic             clk_sys,            // clock
  input wire logic             rst,                // reset
  input wire pmc_pkg::pmc_op_t op,                 // op strobes
  input wire logic             busy,               // sequence
  input wire logic             irq_taken,          // irq entry
  input wire logic [15:0]      sp_in,              // stack pointer
  input wire logic [15:0]      irq_user,           // user mask
  input wire logic [15:0]      irq_lvl_in,         // raw levels
  input wire pmc_pkg::pmc_io_t io_in,              // core request
  input wire logic             restricted,         // mode
  input wire logic [7:0]       mode_history_stack, // stack
  input wire logic             op_done,            // sequence end
  input wire logic [15:0]      sp_out,             // new pointer
  input wire logic             carry_out,          // carry
  input wire logic             e_alt_load,         // alt load
  input wire logic             sys_viol_irq,       // violation
  input wire logic             ack_sys_viol,       // acknowledge
  input wire logic [1:0]       viol_level,         // level
  input wire logic [15:0]      irq_lvl_out,        // clamped
  input wire pmc_pkg::pmc_io_t io_out              // gated request
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [15:0] lvl_exp;
  // ==========================================================
  // expected levels; two bits per source
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      lvl_exp[2*i +: 2] = (irq_user[i] && irq_lvl_in[2*i +: 2] == 2'h3)
                          ? 2'h2 : irq_lvl_in[2*i +: 2];
    end
  end
  // ==========================================================
  // assertions
  a_enter_user_shift: assert property (
    !busy && op.set_user && !irq_taken |=>
    mode_history_stack == {$past(mode_history_stack[5:0]), 2'h1})
    else $error("enter-user shift wrong");
  a_restore_rotate: assert property (
    !busy && op.restore && !op.set_user && !irq_taken |=>
    mode_history_stack == {$past(mode_history_stack[1:0]),
                           $past(mode_history_stack[7:2])})
    else $error("restore rotate wrong");
  a_read_mode_carry: assert property (
    !busy && op.read_mode |=> carry_out == $past(mode_history_stack[0]))
    else $error("carry not stack bit0");
  a_save_nine_clks: assert property (
    !busy && op.save |-> ##9
    (op_done && sp_out == $past(sp_in, 9) - 16'h0001))
    else $error("save timing or pointer wrong");
  a_detect_raises: assert property (
    !busy && op.detect && !op.alternate_destination_prefix &&
    restricted |=> sys_viol_irq)
    else $error("detect in restricted missed");
  a_ack_clears_viol: assert property (
    ack_sys_viol &&
    !(!busy && op.detect && !op.alternate_destination_prefix && restricted)
    |=> !sys_viol_irq)
    else $error("acknowledge did not clear");
  a_alt_no_viol: assert property (
    !busy && op.detect && op.alternate_destination_prefix && !sys_viol_irq
    |=> e_alt_load && !sys_viol_irq)
    else $error("alternate load wrong");
  a_level_clamp: assert property (
    1'b1 |=> irq_lvl_out == $past(lvl_exp))
    else $error("level clamp wrong");
  a_viol_level_top: assert property (
    !$past(rst) |-> viol_level == 2'h3)
    else $error("violation level not 3");
  a_deny_ctrl_page: assert property (
    restricted && io_in.wr && io_in.addr[15:8] == 8'h04 |=> !io_out.wr)
    else $error("protected page write passed");
  c_enter_user: cover property (!busy && op.set_user);
  c_sys_call: cover property (!busy && op.system_call_op ##10 op_done);
  c_io_gated: cover property (restricted && io_in.wr);
endmodule

// file: tb/pmc_top_tb_top.sv
// Purpose: directed test of privilege mode control
// Assumes: inputs driven at falling edge
// Notes:   op codes are 9-bit images of the op struct
`timescale 1ns/1ps
module pmc_top_tb_top;
  logic             clk_sys = 1'b0, rst = 1'b1, irq_taken = 1'b0;
  logic             io_bank_hit = 1'b0, mem_wr = 1'b0, wp_hit = 1'b0;
  logic             ack_sys_viol = 1'b0, ack_wp_viol = 1'b0;
  pmc_pkg::pmc_op_t op = '0;
  pmc_pkg::pmc_io_t io_in = '0, io_out;
  logic [15:0]      sp_in = '0, irq_user = '0, irq_lvl_in = '0;
  logic [15:0]      sp_out, mem_addr, irq_lvl_out;
  logic [7:0]       wp_control = '0, bank_strobe_in = 8'hff;
  logic [7:0]       mem_rdata, mem_wdata, mode_history_stack;
  logic [7:0]       bank_strobe_out;
  logic [4:0]       io_periph_id = 5'h1f;
  logic [2:0]       io_bank_sel = '0;
  logic [1:0]       viol_level;
  logic             restricted, busy, op_done, mem_we, sp_we, vector_jump;
  logic             carry_we, carry_out, e_self_load, e_alt_load;
  logic             sys_viol_irq, wp_viol_irq, io_dropped, dual_mode_flag;
  int               fails = 0, samples_checked = 0, n;

  pmc_top DUT (.*);
  pmc_core_model MEM (.clk_sys, .mem_we, .mem_addr, .mem_wdata,
                      .rd_addr(sp_in), .mem_rdata);
  always #5 clk_sys = ~clk_sys;
  // ==========================================================
  // compare and verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // one op for a single edge; returns with its results settled
  task automatic pulse(input pmc_pkg::pmc_op_t o);
    @(negedge clk_sys);
    op = o;
    @(negedge clk_sys);
    op = '0;
  endtask
  // long op; bounded wait, counts edges up to the done pulse
  task automatic run_seq(input pmc_pkg::pmc_op_t o, input int clks);
    pulse(o);
    n = 1;
    while (op_done !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 20) begin
      fails++;
      final_report();
    end else begin
      check(16'(n), 16'(clks));
    end
  endtask
  task automatic io_wr(input logic [15:0] a, input logic [4:0] id,
                       input logic [7:0] d);
    @(negedge clk_sys);
    io_in = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
    io_periph_id = id;
    @(negedge clk_sys);
    io_in = '0;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    check(16'(mode_history_stack), 16'h0000);
    check(16'(viol_level), 16'h0003);
    io_wr(16'h0420, 5'h16, 8'h01);
    check(16'(io_out.wr), 16'h0001);
    check(16'(dual_mode_flag), 16'h0001);
    pulse(9'h008);
    check(16'(e_self_load), 16'h0001);
    pulse(9'h100);
    check(16'({restricted, mode_history_stack}), 16'h0101);
    pulse(9'h010);
    check(16'({carry_we, carry_out}), 16'h0003);
    // restricted writes with nothing enabled are all lost
    io_wr(16'h000e, 5'h1f, 8'h5a);
    check(16'(io_dropped), 16'h0001);
    io_wr(16'h0030, 5'h02, 8'h5a);
    check(16'(io_out.wr), 16'h0000);
    io_wr(16'h0050, 5'h1f, 8'h5a);
    check(16'(io_out.wr), 16'h0000);
    // a restricted read of a denied page still passes
    @(negedge clk_sys);
    io_in = '{wr: 1'b0, rd: 1'b1, addr: 16'h0420, data: 8'h00};
    @(negedge clk_sys);
    io_in = '0;
    check(16'({io_out.rd, io_dropped}), 16'h0002);
    io_bank_hit = 1'b1;
    io_bank_sel = 3'h3;
    io_wr(16'h00a3, 5'h0a, 8'h5a);
    check(16'(io_out.wr), 16'h0000);
    check(16'(bank_strobe_out), 16'h0000);
    io_bank_hit = 1'b0;
    pulse(9'h008);
    check(16'(sys_viol_irq), 16'h0001);
    ack_sys_viol = 1'b1;
    @(negedge clk_sys);
    ack_sys_viol = 1'b0;
    check(16'(sys_viol_irq), 16'h0000);
    pulse(9'h00c);
    check(16'({e_alt_load, sys_viol_irq}), 16'h0002);
    mem_wr = 1'b1;
    wp_hit = 1'b1;
    irq_user = 16'h0001;
    irq_lvl_in = 16'h00ff;
    @(negedge clk_sys);
    mem_wr = 1'b0;
    wp_hit = 1'b0;
    check(16'(wp_viol_irq), 16'h0001);
    check(irq_lvl_out, 16'h00fe);
    // system call back to privileged, then enable two places
    sp_in = 16'h0040;
    run_seq(9'h002, 10);
    check(sp_out, 16'h003e);
    check(16'({sp_we, busy}), 16'h0002);
    check(16'({vector_jump, mode_history_stack}), 16'h0104);
    io_wr(16'h0330, 5'h02, 8'h01);
    io_wr(16'h0380, 5'h0a, 8'h08);
    pulse(9'h100);
    io_wr(16'h0030, 5'h02, 8'h3c);
    check(16'({io_out.wr, io_out.data}), 16'h013c);
    // enabled owner still cannot reach the protection page
    io_wr(16'h0420, 5'h02, 8'h00);
    check(16'({io_dropped, dual_mode_flag}), 16'h0003);
    io_bank_hit = 1'b1;
    io_wr(16'h00a3, 5'h0a, 8'h11);
    check(16'({io_out.wr, bank_strobe_out}), 16'h0108);
    io_bank_hit = 1'b0;
    // save, scramble with restore, load back
    sp_in = 16'h0020;
    run_seq(9'h040, 9);
    check(16'({mem_we, mem_wdata}), 16'h0111);
    check(mem_addr, 16'h001f);
    check(sp_out, 16'h001f);
    pulse(9'h080);
    check(16'(mode_history_stack), 16'h0044);
    sp_in = 16'h001f;
    run_seq(9'h020, 7);
    check(16'(mode_history_stack), 16'h0011);
    check(sp_out, 16'h0020);
    check(mem_addr, 16'h001f);
    @(negedge clk_sys);
    irq_taken = 1'b1;
    ack_wp_viol = 1'b1;
    @(negedge clk_sys);
    irq_taken = 1'b0;
    ack_wp_viol = 1'b0;
    mem_wr = 1'b1;
    wp_hit = 1'b1;
    check(16'(mode_history_stack), 16'h0044);
    check(16'(wp_viol_irq), 16'h0000);
    @(negedge clk_sys);
    wp_control = 8'h01;
    check(16'(wp_viol_irq), 16'h0000);
    // nonzero control protects privileged writes as well
    @(negedge clk_sys);
    mem_wr = 1'b0;
    wp_hit = 1'b0;
    check(16'(wp_viol_irq), 16'h0001);
    final_report();
  end
endmodule
bind pmc_top pmc_props CHK (.*);

// file: verilog/pmc_pkg.sv
// Purpose: shared constants and carriers for privilege mode control
// Assumes: 8-bit core, 16-bit internal i/o address space
// Notes:   enable registers are write-only, reads are not answered here
//
// Operation
// - push current mode on each mode change
// - enter-user shifts left, inserts restricted code
// - restore rotates stack right two bits
// - privileged only via interrupt, call, restart
// - save 9 clocks predecrement, load 7 clocks
// - read-mode copies stack bit0 to carry
// - detect op in restricted sets violation
// - otherwise detect op is register self-load
// - alternate prefix forces alternate load always
// - system call: sp minus two, jump, 10 clocks
// - dual-mode enable register gates whole mechanism
// - peripheral enables reset clear, gate writes
// - uncovered i/o writes discarded in restricted
// - disabled bank: ignore control write, strobe
// - control ranges always denied in restricted
// - restricted protected write raises violation
// - privileged unprotected when control is zero
// - level 3 unavailable from restricted sources
// - privileged mode reaches everything
// - user level 3 request lowered to 2
// - violation interrupts only at level 3
// - acknowledge clears pending violation
package pmc_pkg;

  // ==========================================================
  // register map
  localparam int          NUM_UA        = 22;
  localparam int          NUM_REG       = 23;
  localparam logic [15:0] REG_OFF [NUM_REG] = '{
    16'h0300, 16'h0320, 16'h0330, 16'h0338, 16'h0340, 16'h0348,
    16'h0350, 16'h0358, 16'h0360, 16'h0370, 16'h0380, 16'h0388,
    16'h0390, 16'h0398, 16'h03a0, 16'h03b0, 16'h03c0, 16'h03c8,
    16'h03d0, 16'h03d8, 16'h03e0, 16'h03f0, 16'h0420};
  localparam int          IDX_IO_BANK   = 10;  // io_bank_user_access
  localparam int          IDX_DUAL      = 22;  // dual_mode_enable
  localparam logic [4:0]  PERIPH_NONE   = 5'h1f;
  localparam logic [7:0]  REG_RESET     = 8'h00;
  localparam int          DUAL_FLAG_BIT = 0;

  // ==========================================================
  // ranges always denied in restricted
  localparam logic [15:0] CTRL_LOW_END  = 16'h001c;
  localparam logic [7:0]  UA_PAGE       = 8'h03;
  localparam logic [7:0]  MPROT_PAGE    = 8'h04;

  // ==========================================================
  // mode stack codes
  localparam logic [1:0]  MODE_PRIV     = 2'h0;
  localparam logic [1:0]  MODE_RESTR    = 2'h1;
  localparam logic [7:0]  STACK_RESET   = 8'h00;
  localparam logic [7:0]  WP_OFF        = 8'h00;

  // ==========================================================
  // timing in processor clocks
  localparam logic [3:0]  SAVE_CLKS     = 4'h9;
  localparam logic [3:0]  LOAD_CLKS     = 4'h7;
  localparam logic [3:0]  CALL_CLKS     = 4'ha;
  localparam logic [15:0] SP_DEC_SAVE   = 16'h0001;
  localparam logic [15:0] SP_DEC_CALL   = 16'h0002;
  localparam logic [15:0] SP_INC_LOAD   = 16'h0001;

  // ==========================================================
  // interrupt levels
  localparam int          NUM_IRQ       = 8;
  localparam logic [1:0]  LVL_TOP       = 2'h3;
  localparam logic [1:0]  LVL_USER_MAX  = 2'h2;

  typedef enum logic [1:0] {
    PMC_IDLE = 2'b00,
    PMC_SAVE = 2'b01,
    PMC_LOAD = 2'b10,
    PMC_CALL = 2'b11
  } pmc_seq_t;

  // i/o bus write or read request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  data;
  } pmc_io_t;

  // decoded opcode strobes from the core
  typedef struct packed {
    logic set_user;
    logic restore;
    logic save;
    logic load;
    logic read_mode;
    logic detect;
    logic alternate_destination_prefix;
    logic system_call_op;
    logic restart;
  } pmc_op_t;

endpackage

// file: verilog/pmc_top.sv
// Purpose: two-tier privilege mode stack, violations and i/o write gate
// Assumes: all inputs come from logic on clk_sys, so none is synchronised
// Notes:   one op strobe per cycle; ops arriving while busy are dropped
`timescale 1ns/1ps
module pmc_top (
  input  wire logic             clk_sys,          // processor clock
  input  wire logic             rst,              // async reset, high
  input  wire pmc_pkg::pmc_op_t op,               // opcode strobes
  input  wire logic             irq_taken,        // interrupt entry pulse
  input  wire logic [15:0]      sp_in,            // current stack pointer
  input  wire logic [7:0]       mem_rdata,        // load data at sp
  input  wire pmc_pkg::pmc_io_t io_in,            // core i/o request
  input  wire logic [4:0]       io_periph_id,     // owning enable index
  input  wire logic             io_bank_hit,      // bank control access
  input  wire logic [2:0]       io_bank_sel,      // bank number
  input  wire logic [7:0]       bank_strobe_in,   // raw bank strobes
  input  wire logic             mem_wr,           // memory write cycle
  input  wire logic             wp_hit,           // protected segment
  input  wire logic [7:0]       wp_control,       // write protect ctrl
  input  wire logic             ack_sys_viol,     // ack mode violation
  input  wire logic             ack_wp_viol,      // ack protect viol
  input  wire logic [15:0]      irq_user,         // user-assigned mask
  input  wire logic [15:0]      irq_lvl_in,       // 2 bits per source
  output logic [7:0]            mode_history_stack, // stack register
  output logic                  restricted,       // effective mode
  output logic                  busy,             // sequence running
  output logic                  op_done,          // sequence end pulse
  output logic                  mem_we,           // mode byte store
  output logic [15:0]           mem_addr,         // store/load address
  output logic [7:0]            mem_wdata,        // stored mode byte
  output logic                  sp_we,            // stack pointer load
  output logic [15:0]           sp_out,           // new stack pointer
  output logic                  vector_jump,      // call vector jump
  output logic                  carry_we,         // carry update
  output logic                  carry_out,        // carry value
  output logic                  e_self_load,      // register self-load
  output logic                  e_alt_load,       // alternate load
  output logic                  sys_viol_irq,     // mode violation req
  output logic                  wp_viol_irq,      // protect viol req
  output logic [1:0]            viol_level,       // violation level
  output logic [15:0]           irq_lvl_out,      // clamped levels
  output pmc_pkg::pmc_io_t      io_out,           // gated i/o request
  output logic                  io_dropped,       // write discarded
  output logic [7:0]            bank_strobe_out,  // gated strobes
  output logic                  dual_mode_flag    // mechanism enabled
);

  // ==========================================================
  // state declarations
  logic [7:0]        ua_reg [pmc_pkg::NUM_REG];
  logic [7:0]        next_ua_reg [pmc_pkg::NUM_REG];
  logic [7:0]        next_stack;
  pmc_pkg::pmc_seq_t seq;
  pmc_pkg::pmc_seq_t next_seq;
  logic [3:0]        cnt;
  logic [3:0]        next_cnt;
  logic [15:0]       sp_hold;
  logic [15:0]       next_sp_hold;
  logic              next_busy;
  logic              next_op_done;
  logic              next_mem_we;
  logic [15:0]       next_mem_addr;
  logic [7:0]        next_mem_wdata;
  logic              next_sp_we;
  logic [15:0]       next_sp_out;
  logic              next_vector_jump;
  logic              next_carry_we;
  logic              next_carry_out;
  logic              next_e_self_load;
  logic              next_e_alt_load;
  logic              next_sys_viol;
  logic              next_wp_viol;
  logic [15:0]       next_irq_lvl;
  pmc_pkg::pmc_io_t  next_io_out;
  logic              next_io_dropped;
  logic [7:0]        next_strobe;
  logic              now_restricted;
  logic              idle;
  logic              last_clk;
  logic [3:0]        seq_len;
  logic              denied_range;
  logic              periph_ok;
  logic              write_ok;
  logic              next_restricted;

  // mechanism off means no restricted behaviour anywhere
  assign dual_mode_flag = ua_reg[pmc_pkg::IDX_DUAL][pmc_pkg::DUAL_FLAG_BIT];
  // bit 0 of the stack is the current mode
  assign now_restricted = dual_mode_flag && mode_history_stack[0];
  assign idle           = (seq == pmc_pkg::PMC_IDLE);

  // ==========================================================
  // sequence length for multi-clock stack ops
  always_comb begin
    case (seq)
      pmc_pkg::PMC_SAVE: seq_len = pmc_pkg::SAVE_CLKS;
      pmc_pkg::PMC_LOAD: seq_len = pmc_pkg::LOAD_CLKS;
      pmc_pkg::PMC_CALL: seq_len = pmc_pkg::CALL_CLKS;
      default:           seq_len = 4'h1;
    endcase
  end
  assign last_clk = !idle && (cnt == seq_len - 4'h1);

  // ==========================================================
  // mode stack and op sequencer
  always_comb begin
    next_stack       = mode_history_stack;
    next_seq         = seq;
    next_cnt         = cnt;
    next_sp_hold     = sp_hold;
    next_op_done     = 1'b0;
    next_mem_we      = 1'b0;
    next_mem_addr    = mem_addr;
    next_mem_wdata   = mem_wdata;
    next_sp_we       = 1'b0;
    next_sp_out      = sp_out;
    next_vector_jump = 1'b0;
    next_carry_we    = 1'b0;
    next_carry_out   = carry_out;
    next_e_self_load = 1'b0;
    next_e_alt_load  = 1'b0;
    if (idle) begin
      if (op.set_user) begin
        // push with restricted code on top, in bits 1:0
        next_stack = {mode_history_stack[5:0], pmc_pkg::MODE_RESTR};
      end else if (op.restore) begin
        // rotate right back to the previous mode
        next_stack = {mode_history_stack[1:0], mode_history_stack[7:2]};
      end else if (op.system_call_op || op.restart) begin
        // call and restart enter privileged mode at once
        next_stack = {mode_history_stack[5:0], pmc_pkg::MODE_PRIV};
      end
      if (op.read_mode) begin
        // only the carry flag is touched
        next_carry_we  = 1'b1;
        next_carry_out = mode_history_stack[0];
      end
      if (op.detect) begin
        if (op.alternate_destination_prefix) begin
          next_e_alt_load = 1'b1;
        end else if (!now_restricted) begin
          next_e_self_load = 1'b1;
        end
      end
      next_sp_hold = sp_in;
      next_cnt     = 4'h1;
      if (op.save) begin
        next_seq = pmc_pkg::PMC_SAVE;
      end else if (op.load) begin
        next_seq = pmc_pkg::PMC_LOAD;
      end else if (op.system_call_op) begin
        next_seq = pmc_pkg::PMC_CALL;
      end
    end else if (last_clk) begin
      next_seq     = pmc_pkg::PMC_IDLE;
      next_cnt     = 4'h0;
      next_op_done = 1'b1;
      next_sp_we   = 1'b1;
      case (seq)
        pmc_pkg::PMC_SAVE: begin
          // predecrement then store the mode byte
          next_sp_out    = sp_hold - pmc_pkg::SP_DEC_SAVE;
          next_mem_addr  = sp_hold - pmc_pkg::SP_DEC_SAVE;
          next_mem_wdata = mode_history_stack;
          next_mem_we    = 1'b1;
        end
        pmc_pkg::PMC_LOAD: begin
          next_stack    = mem_rdata;
          next_mem_addr = sp_hold;
          next_sp_out   = sp_hold + pmc_pkg::SP_INC_LOAD;
        end
        pmc_pkg::PMC_CALL: begin
          // room for the return address, then vector
          next_sp_out      = sp_hold - pmc_pkg::SP_DEC_CALL;
          next_vector_jump = 1'b1;
        end
        default: begin
          next_sp_we = 1'b0;
        end
      endcase
    end else begin
      next_cnt = cnt + 4'h1;
    end
    // interrupt entry pushes privileged code on top of the result of any same-cycle stack op
    if (irq_taken) begin
      next_stack = {next_stack[5:0], pmc_pkg::MODE_PRIV};
    end
  end
  assign next_busy = (next_seq != pmc_pkg::PMC_IDLE);

  // stack and sequencer registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_history_stack <= pmc_pkg::STACK_RESET;
      seq                <= pmc_pkg::PMC_IDLE;
      cnt                <= 4'h0;
      sp_hold            <= 16'h0000;
      busy               <= 1'b0;
      op_done            <= 1'b0;
      mem_we             <= 1'b0;
      mem_addr           <= 16'h0000;
      mem_wdata          <= 8'h00;
      sp_we              <= 1'b0;
      sp_out             <= 16'h0000;
      vector_jump        <= 1'b0;
      carry_we           <= 1'b0;
      carry_out          <= 1'b0;
      e_self_load        <= 1'b0;
      e_alt_load         <= 1'b0;
    end else begin
      mode_history_stack <= next_stack;
      seq                <= next_seq;
      cnt                <= next_cnt;
      sp_hold            <= next_sp_hold;
      busy               <= next_busy;
      op_done            <= next_op_done;
      mem_we             <= next_mem_we;
      mem_addr           <= next_mem_addr;
      mem_wdata          <= next_mem_wdata;
      sp_we              <= next_sp_we;
      sp_out             <= next_sp_out;
      vector_jump        <= next_vector_jump;
      carry_we           <= next_carry_we;
      carry_out          <= next_carry_out;
      e_self_load        <= next_e_self_load;
      e_alt_load         <= next_e_alt_load;
    end
  end

  // ==========================================================
  // violation flags; set beats acknowledge in the same cycle
  always_comb begin
    next_sys_viol = sys_viol_irq;
    next_wp_viol  = wp_viol_irq;
    if (ack_sys_viol) begin
      next_sys_viol = 1'b0;
    end
    if (ack_wp_viol) begin
      next_wp_viol = 1'b0;
    end
    // detect op while restricted, no prefix
    if (idle && op.detect && !op.alternate_destination_prefix &&
        now_restricted) begin
      next_sys_viol = 1'b1;
    end
    // privileged writes checked only when control nonzero
    if (mem_wr && wp_hit &&
        (now_restricted || (wp_control != pmc_pkg::WP_OFF))) begin
      next_wp_viol = 1'b1;
    end
  end

  // ==========================================================
  // level clamp for user-assigned interrupt sources
  genvar gi;
  generate
    for (gi = 0; gi < pmc_pkg::NUM_IRQ; gi = gi + 1) begin : g_lvl
      // user sources never request the top level
      assign next_irq_lvl[2*gi+1:2*gi] =
        (irq_user[gi] && (irq_lvl_in[2*gi+1:2*gi] == pmc_pkg::LVL_TOP)) ?
        pmc_pkg::LVL_USER_MAX : irq_lvl_in[2*gi+1:2*gi];
    end
  endgenerate

  // violation and level registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sys_viol_irq <= 1'b0;
      wp_viol_irq  <= 1'b0;
      viol_level   <= 2'h0;
      irq_lvl_out  <= 16'h0000;
    end else begin
      sys_viol_irq <= next_sys_viol;
      wp_viol_irq  <= next_wp_viol;
      // violations always ride the top level
      viol_level   <= pmc_pkg::LVL_TOP;
      irq_lvl_out  <= next_irq_lvl;
    end
  end

  // ==========================================================
  // i/o write gate
  always_comb begin
    denied_range = (io_in.addr <= pmc_pkg::CTRL_LOW_END) ||
                   (io_in.addr[15:8] == pmc_pkg::UA_PAGE) ||
                   (io_in.addr[15:8] == pmc_pkg::MPROT_PAGE);
    periph_ok = 1'b0;
    // no owning enable means never writable when restricted
    if (io_periph_id < 5'(pmc_pkg::NUM_UA)) begin
      if (io_bank_hit) begin
        // per-bank bit guards bank control writes
        periph_ok = ua_reg[pmc_pkg::IDX_IO_BANK][io_bank_sel];
      end else begin
        // any set bit opens the peripheral
        periph_ok = (ua_reg[io_periph_id] != pmc_pkg::REG_RESET);
      end
    end
    write_ok = !now_restricted || (!denied_range && periph_ok);
    next_io_out    = io_in;
    // only writes are gated, reads pass untouched
    next_io_out.wr = io_in.wr && write_ok;
    next_io_dropped = io_in.wr && !write_ok;
    // disabled banks lose their strobe when restricted
    next_strobe = now_restricted ?
                  (bank_strobe_in & ua_reg[pmc_pkg::IDX_IO_BANK]) :
                  bank_strobe_in;
  end

  // ==========================================================
  // enable register decode, one entry per register
  generate
    for (gi = 0; gi < pmc_pkg::NUM_REG; gi = gi + 1) begin : g_reg
      // accepted writes land in the matching register
      assign next_ua_reg[gi] =
        (next_io_out.wr && (io_in.addr == pmc_pkg::REG_OFF[gi])) ?
        io_in.data : ua_reg[gi];
    end
  endgenerate

  // mode output follows a dual-mode write landing at the same edge
  assign next_restricted =
    next_ua_reg[pmc_pkg::IDX_DUAL][pmc_pkg::DUAL_FLAG_BIT] && next_stack[0];

  // gate and enable registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < pmc_pkg::NUM_REG; i++) begin
        ua_reg[i] <= pmc_pkg::REG_RESET;
      end
      io_out          <= '0;
      io_dropped      <= 1'b0;
      bank_strobe_out <= 8'h00;
      restricted      <= 1'b0;
    end else begin
      for (int i = 0; i < pmc_pkg::NUM_REG; i++) begin
        ua_reg[i] <= next_ua_reg[i];
      end
      io_out          <= next_io_out;
      io_dropped      <= next_io_dropped;
      bank_strobe_out <= next_strobe;
      restricted      <= next_restricted;
    end
  end

endmodule
